// file: lcmb_pkg.sv
package lcmb_pkg;

    localparam int unsigned CLK_HZ = 100000000;
    localparam int unsigned ENG_CLK_HZ = 32768;
    localparam int unsigned ENG_TICK_DIV = CLK_HZ / ENG_CLK_HZ;
    localparam logic [11:0] ENG_TICK_LAST = 12'(ENG_TICK_DIV - 1);
    localparam logic [4:0] SLOW_OP_TICKS = 5'h10;

    localparam int unsigned ROW_MSB = 6;
    localparam int unsigned LED_COUNT = 9;
    localparam int unsigned FADER_BIT = 9;
    localparam logic [6:0] SEL_FIRST = 7'h01;
    localparam logic [6:0] SEL_LAST = 7'h09;

    localparam logic [8:0] OP_LOAD_START = 9'h13c;
    localparam logic [8:0] OP_MAP_START = 9'h138;
    localparam logic [8:0] OP_LOAD_END = 9'h139;
    localparam logic [8:0] OP_MAP_SEL = 9'h13a;
    localparam logic [8:0] OP_ROW_STEP = 9'h13b;
    localparam logic [8:0] OP_LOAD_ADDR = 9'h13e;
    localparam logic [8:0] OP_MAP_ADDR = 9'h13f;
    localparam int unsigned STEP_DIR_BIT = 6;
    localparam int unsigned STEP_LOAD_BIT = 0;

    localparam logic [15:0] INSTR_RESTART = 16'h0000;
    localparam logic [15:0] INSTR_ALERT = 16'hc400;
    localparam logic [15:0] INSTR_SYNC_FLUSH = 16'he000;
    localparam logic [2:0] PFX_END = 3'h6;
    localparam logic [10:0] END_LOW_ZERO = 11'h000;
    localparam int unsigned END_ALERT_BIT = 12;
    localparam int unsigned END_RESET_BIT = 11;
    localparam logic [2:0] PFX_BRANCH = 3'h5;
    localparam logic [6:0] PFX_BRANCH_VAR = 7'h43;
    localparam logic [2:0] PFX_SYNC = 3'h7;
    localparam logic [4:0] PFX_SKIP = 5'h11;

    localparam int unsigned SYNC_WAIT_EXT_BIT = 12;
    localparam int unsigned SYNC_SEND_EXT_BIT = 6;

    localparam logic [1:0] SKIP_UNEQUAL = 2'h0;
    localparam logic [1:0] SKIP_BELOW = 2'h1;
    localparam logic [1:0] SKIP_AT_LEAST = 2'h2;
    localparam logic [1:0] SKIP_EQUAL = 2'h3;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_FETCH = 3'b010,
        ST_WAIT = 3'b100
    } lcmb_state_t;

endpackage

// file: lcmb_tick_div.sv
`timescale 1ns/1ns
module lcmb_tick_div
    import lcmb_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    output logic tick
);

    logic [11:0] cnt_q;

    // The engine rate is a one-cycle pulse every ENG_TICK_DIV cycles.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt_q <= 12'h000;
            tick <= 1'b0;
        end
        else if (cnt_q == ENG_TICK_LAST)
        begin
            cnt_q <= 12'h000;
            tick <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 12'h001;
            tick <= 1'b0;
        end
    end

endmodule

// file: lcmb_decode.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Origin and final-row operations set table bounds, addresses 0 to 127.
// - Origin-and-activate records start and makes that row the active map.
// - Single attach connects one driver for select 1..9, else none.
// - Unmapped LEDs keep following their own duty register.
// - Detach-all removes every driver connection of this engine.
// - Row advance moves forward one, wrapping from end to start.
// - Row retreat moves back one, wrapping from start to end.
// - No duty value is pushed until a duty write or slope executes.
// - Advance-only and retreat-only step the pointer, leave connections.
// - Row-jump-activate loads pointer from bits 6:0 and activates it.
// - Row-jump-only loads pointer from bits 6:0, no activation.
// - Branch loads step number as offset from the program base.
// - Loop count sets repeats; every branch keeps its own tracking.
// - A branch occupies the engine for 16 engine clock cycles.
// - Skip prefix 10001, condition code, count, two variable fields.
// - Several drivers attach only through mapping table rows.
// - Table row bits 8:0 enable drivers, bit 9 enables master fader.
// - Engine 1 beats engines 2 and 3, engine 2 beats engine 3.
// - Host duty writes have no effect on engine-owned LEDs.
// - Sync wait bits: 7, 8, 9 for engines, 12 for external line.
module lcmb_decode
    import lcmb_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    output logic instr_ready,
    input wire logic [7:0] cur_pc,
    input wire logic [7:0] prog_base,
    output logic [1:0] var_sel,
    input wire logic [7:0] var_data,
    output logic pc_load,
    output logic [7:0] pc_target,
    output logic sram_rd,
    output logic [6:0] sram_addr,
    input wire logic [15:0] sram_rdata,
    input wire logic [8:0] higher_map,
    input wire logic [8:0] host_duty_we,
    input wire logic duty_push,
    output logic [8:0] led_map,
    output logic fader_en,
    output logic [8:0] led_own,
    output logic [8:0] duty_host_we_eff,
    output logic [8:0] duty_eng_we,
    output logic [6:0] row_ptr,
    output logic [6:0] table_start,
    output logic [6:0] table_end,
    output logic alert_pulse,
    output logic end_pulse,
    output logic end_alert,
    output logic end_reset,
    output logic sync_pulse,
    output logic [3:0] sync_wait,
    output logic [3:0] sync_send,
    output logic sync_flush_pulse,
    output logic skip_pulse,
    output logic [1:0] skip_cond,
    output logic [4:0] skip_count,
    output logic [1:0] skip_var1,
    output logic [1:0] skip_var2
);

    lcmb_state_t state_q;
    logic eng_tick;
    logic take;
    logic [8:0] op9;
    logic is_restart;
    logic is_alert;
    logic is_end;
    logic is_flush;
    logic is_sync;
    logic is_br;
    logic is_brv;
    logic is_skip;
    logic activating;
    logic slow_op;
    logic [6:0] step_row;
    logic [8:0] sel_map;
    logic [5:0] br_count;
    logic [6:0] br_step;
    logic [4:0] ticks_q;
    logic [5:0] loop_cnt_q [256];
    logic [255:0] loop_act_q;
    logic [15:0] instr_q;

    lcmb_tick_div u_tick
    (
        .clk(clk),
        .rst_n(rst_n),
        .tick(eng_tick)
    );

    assign instr_ready = (state_q == ST_IDLE);
    assign take = instr_valid && instr_ready;
    assign op9 = instr[15:7];
    assign var_sel = instr[1:0];

    always_comb
    begin
        is_restart = (instr == INSTR_RESTART);
        is_alert = (instr == INSTR_ALERT);
        is_flush = (instr == INSTR_SYNC_FLUSH);
        is_end = (instr[15:13] == PFX_END) && (instr[10:0] == END_LOW_ZERO);
        is_sync = (instr[15:13] == PFX_SYNC) && !is_flush;
        is_br = (instr[15:13] == PFX_BRANCH);
        is_brv = (instr[15:9] == PFX_BRANCH_VAR);
        is_skip = (instr[15:11] == PFX_SKIP);
        br_count = is_brv ? var_data[5:0] : instr[12:7];
        br_step = is_brv ? instr[8:2] : instr[6:0];
        activating = (op9 == OP_MAP_START) || (op9 == OP_MAP_ADDR)
            || ((op9 == OP_ROW_STEP) && !instr[STEP_LOAD_BIT]);
        slow_op = is_restart || is_end || is_br || is_brv || is_sync;
    end

    always_comb
    begin
        if (instr[STEP_DIR_BIT])
        begin
            step_row = (row_ptr == table_start) ? table_end
                : row_ptr - 7'h01;
        end
        else
        begin
            step_row = (row_ptr == table_end) ? table_start
                : row_ptr + 7'h01;
        end
    end

    // Only one driver can come out of a single attach.
    always_comb
    begin
        sel_map = 9'h000;
        if (instr[6:0] >= SEL_FIRST && instr[6:0] <= SEL_LAST)
        begin
            sel_map = 9'h001 << (instr[3:0] - 4'h1);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_q <= ST_IDLE;
            ticks_q <= 5'h00;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    if (take && activating)
                    begin
                        state_q <= ST_FETCH;
                    end
                    else if (take && slow_op)
                    begin
                        state_q <= ST_WAIT;
                        ticks_q <= SLOW_OP_TICKS;
                    end
                end
                ST_FETCH:
                begin
                    state_q <= ST_IDLE;
                end
                ST_WAIT:
                begin
                    if (eng_tick)
                    begin
                        ticks_q <= ticks_q - 5'h01;
                        if (ticks_q == 5'h01)
                        begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Table bounds, row pointer and the row read.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            table_start <= 7'h00;
            table_end <= 7'h00;
            row_ptr <= 7'h00;
            sram_rd <= 1'b0;
            sram_addr <= 7'h00;
        end
        else
        begin
            sram_rd <= 1'b0;
            if (take)
            begin
                unique case (op9)
                    OP_LOAD_START: table_start <= instr[6:0];
                    OP_LOAD_END: table_end <= instr[6:0];
                    OP_MAP_START:
                    begin
                        table_start <= instr[6:0];
                        row_ptr <= instr[6:0];
                        sram_rd <= 1'b1;
                        sram_addr <= instr[6:0];
                    end
                    OP_ROW_STEP:
                    begin
                        row_ptr <= step_row;
                        sram_rd <= !instr[STEP_LOAD_BIT];
                        sram_addr <= step_row;
                    end
                    OP_LOAD_ADDR: row_ptr <= instr[6:0];
                    OP_MAP_ADDR:
                    begin
                        row_ptr <= instr[6:0];
                        sram_rd <= 1'b1;
                        sram_addr <= instr[6:0];
                    end
                    default:
                    begin
                    end
                endcase
            end
        end
    end

    // Active connections: from a fetched row or from a single attach.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            led_map <= 9'h000;
            fader_en <= 1'b0;
        end
        else if (state_q == ST_FETCH)
        begin
            led_map <= sram_rdata[LED_COUNT-1:0];
            fader_en <= sram_rdata[FADER_BIT];
        end
        else if (take && op9 == OP_MAP_SEL)
        begin
            led_map <= sel_map;
            fader_en <= 1'b0;
        end
    end

    assign led_own = led_map & ~higher_map;
    assign duty_host_we_eff = host_duty_we & ~led_own;
    assign duty_eng_we = duty_push ? led_own : 9'h000;

    // Each branch address keeps its own loop state, so nesting is unlimited.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            loop_act_q <= '0;
            for (int i = 0; i < 256; i++)
            begin
                loop_cnt_q[i] <= 6'h00;
            end
            pc_load <= 1'b0;
            pc_target <= 8'h00;
        end
        else
        begin
            pc_load <= 1'b0;
            if (take && is_restart)
            begin
                pc_load <= 1'b1;
                pc_target <= prog_base;
            end
            else if (take && (is_br || is_brv))
            begin
                pc_target <= prog_base + {1'b0, br_step};
                if (br_count == 6'h00)
                begin
                    pc_load <= 1'b1;
                end
                else if (!loop_act_q[cur_pc])
                begin
                    loop_act_q[cur_pc] <= 1'b1;
                    loop_cnt_q[cur_pc] <= br_count - 6'h01;
                    pc_load <= 1'b1;
                end
                else if (loop_cnt_q[cur_pc] == 6'h00)
                begin
                    loop_act_q[cur_pc] <= 1'b0;
                end
                else
                begin
                    loop_cnt_q[cur_pc] <= loop_cnt_q[cur_pc] - 6'h01;
                    pc_load <= 1'b1;
                end
            end
        end
    end

    // Flow-control events and their fields.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            instr_q <= 16'h0000;
            alert_pulse <= 1'b0;
            end_pulse <= 1'b0;
            end_alert <= 1'b0;
            end_reset <= 1'b0;
            sync_pulse <= 1'b0;
            sync_wait <= 4'h0;
            sync_send <= 4'h0;
            sync_flush_pulse <= 1'b0;
            skip_pulse <= 1'b0;
        end
        else
        begin
            alert_pulse <= take && is_alert;
            end_pulse <= take && is_end;
            sync_pulse <= take && is_sync;
            sync_flush_pulse <= take && is_flush;
            skip_pulse <= take && is_skip;
            if (take)
            begin
                instr_q <= instr;
            end
            if (take && is_end)
            begin
                end_alert <= instr[END_ALERT_BIT];
                end_reset <= instr[END_RESET_BIT];
            end
            if (take && is_sync)
            begin
                sync_wait <= {instr[SYNC_WAIT_EXT_BIT], instr[9:7]};
                sync_send <= {instr[SYNC_SEND_EXT_BIT], instr[3:1]};
            end
        end
    end

    assign skip_cond = instr_q[10:9];
    assign skip_count = instr_q[8:4];
    assign skip_var1 = instr_q[3:2];
    assign skip_var2 = instr_q[1:0];

    logic [4:0] seen_q;

    // Counts engine ticks spent busy, for checking only.
    always_ff @(posedge clk)
    begin
        if (!rst_n || state_q != ST_WAIT)
        begin
            seen_q <= 5'h00;
        end
        else if (eng_tick)
        begin
            seen_q <= seen_q + 5'h01;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence seq_fetch;
        sram_rd ##1 (instr_ready && !sram_rd);
    endsequence

    a_activate_fetch: assert property (take && activating |=> seq_fetch)
        else $error("activating operation did not fetch its row");
    a_row_loaded: assert property (sram_rd |=> led_map == $past(sram_rdata[8:0]))
        else $error("fetched row not applied to mapping");
    a_next_wrap: assert property (take && op9 == OP_ROW_STEP && !instr[6]
        && row_ptr == table_end |=> row_ptr == table_start)
        else $error("row advance did not wrap to start");
    a_prev_wrap: assert property (take && op9 == OP_ROW_STEP && instr[6]
        && row_ptr == table_start |=> row_ptr == table_end)
        else $error("row retreat did not wrap to end");
    a_load_keeps_map: assert property (take && (op9 == OP_LOAD_ADDR
        || (op9 == OP_ROW_STEP && instr[0])) ##1 !(take && op9 == OP_MAP_SEL)
        |-> $stable(led_map)[*2])
        else $error("load-only operation changed mapping");
    a_sel_single: assert property (take && op9 == OP_MAP_SEL |=>
        $onehot0(led_map) && ((led_map != 9'h000) == (instr_q[6:0] >= 7'h01
        && instr_q[6:0] <= 7'h09)))
        else $error("single attach selected wrong driver count");
    a_branch_time: assert property (state_q == ST_WAIT && eng_tick
        && ticks_q == 5'h01 |-> seen_q == 5'h0f ##1 instr_ready)
        else $error("slow operation not held for 16 engine ticks");
    a_branch_target: assert property (take && is_br && instr[12:7] == 6'h00
        |=> pc_load && pc_target == 8'($past(prog_base) + instr_q[6:0]))
        else $error("branch target not offset from program base");
    a_sync_fields: assert property (take && is_sync |=> sync_pulse
        && sync_wait == {instr_q[12], instr_q[9:7]})
        else $error("sync wait bits misplaced");
    a_host_blocked: assert property (led_own != 9'h000
        |-> (duty_host_we_eff & led_own & ~higher_map) == 9'h000)
        else $error("host write reached engine-owned LED");

endmodule

// file: tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import lcmb_pkg::*;
    logic clk, rst_n, instr_valid, duty_push, instr_ready, pc_load, sram_rd;
    logic fader_en, alert_pulse, end_pulse, end_alert, end_reset, sync_pulse;
    logic sync_flush_pulse, skip_pulse;
    logic [15:0] instr, sram_rdata;
    logic [7:0] cur_pc, prog_base, var_data, pc_target;
    logic [8:0] higher_map, host_duty_we, led_map, led_own;
    logic [8:0] duty_host_we_eff, duty_eng_we;
    logic [6:0] sram_addr, row_ptr, table_start, table_end;
    logic [3:0] sync_wait, sync_send;
    logic [4:0] skip_count;
    logic [1:0] var_sel, skip_cond, skip_var1, skip_var2;
    int mismatches = 0;
    int n_compared = 0;

    lcmb_decode i_lcmb_decode (.clk(clk), .rst_n(rst_n),
        .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready),
        .cur_pc(cur_pc), .prog_base(prog_base), .var_sel(var_sel),
        .var_data(var_data), .pc_load(pc_load), .pc_target(pc_target),
        .sram_rd(sram_rd), .sram_addr(sram_addr), .sram_rdata(sram_rdata),
        .higher_map(higher_map), .host_duty_we(host_duty_we),
        .duty_push(duty_push), .led_map(led_map), .fader_en(fader_en),
        .led_own(led_own), .duty_host_we_eff(duty_host_we_eff),
        .duty_eng_we(duty_eng_we), .row_ptr(row_ptr),
        .table_start(table_start), .table_end(table_end),
        .alert_pulse(alert_pulse), .end_pulse(end_pulse),
        .end_alert(end_alert), .end_reset(end_reset),
        .sync_pulse(sync_pulse), .sync_wait(sync_wait),
        .sync_send(sync_send), .sync_flush_pulse(sync_flush_pulse),
        .skip_pulse(skip_pulse), .skip_cond(skip_cond),
        .skip_count(skip_count), .skip_var1(skip_var1),
        .skip_var2(skip_var2));

    // Memory rows carry the address pattern; unread cycles show the inverse.
    function automatic logic [15:0] row_val(input logic [6:0] r);
        return {6'h00, r[0], r[1], r, 1'b1};
    endfunction
    assign sram_rdata = sram_rd ? row_val(sram_addr) : ~row_val(sram_addr);

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string name, input logic [15:0] seen,
        input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict;
        if (mismatches == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic wait_ready(input int bound, output int cnt);
        cnt = 0;
        while (instr_ready !== 1'b1)
        begin
            @(negedge clk);
            cnt++;
            if (cnt > bound)
            begin
                mismatches++;
                print_verdict();
            end
        end
    endtask

    task automatic issue(input logic [15:0] w);
        int c;
        @(negedge clk);
        wait_ready(20, c);
        instr = w;
        instr_valid = 1'b1;
        @(negedge clk);
        instr_valid = 1'b0;
    endtask

    task automatic do_reset(input int n);
        rst_n = 1'b0;
        repeat (n) @(negedge clk);
        rst_n = 1'b1;
    endtask

    task automatic act(input logic [15:0] w, input logic [6:0] r);
        issue(w);
        chk("sram_rd", 16'(sram_rd), 16'h0001);
        chk("sram_addr", 16'(sram_addr), 16'(r));
        chk("row_ptr", 16'(row_ptr), 16'(r));
        @(negedge clk);
        chk("led_map", 16'(led_map), 16'({r[1], r, 1'b1}));
        chk("fader_en", 16'(fader_en), 16'(r[0]));
    endtask

    task automatic t_table;
        issue({OP_LOAD_START, 7'h7f});
        chk("table_start", 16'(table_start), 16'h007f);
        issue({OP_LOAD_END, 7'h12});
        chk("table_end", 16'(table_end), 16'h0012);
        act({OP_MAP_START, 7'h10}, 7'h10);
        chk("table_start", 16'(table_start), 16'h0010);
        act({OP_ROW_STEP, 7'h00}, 7'h11);
        act({OP_ROW_STEP, 7'h00}, 7'h12);
        act({OP_ROW_STEP, 7'h00}, 7'h10);
        act({OP_ROW_STEP, 7'h40}, 7'h12);
        act({OP_ROW_STEP, 7'h40}, 7'h11);
        issue({OP_ROW_STEP, 7'h01});
        chk("row_ptr", 16'(row_ptr), 16'h0012);
        chk("sram_rd", 16'(sram_rd), 16'h0000);
        issue({OP_ROW_STEP, 7'h41});
        chk("row_ptr", 16'(row_ptr), 16'h0011);
        @(negedge clk);
        chk("led_map", 16'(led_map), 16'h0023);
    endtask

    task automatic t_jump;
        act({OP_MAP_ADDR, 7'h05}, 7'h05);
        issue({OP_LOAD_ADDR, 7'h7f});
        chk("row_ptr", 16'(row_ptr), 16'h007f);
        chk("sram_rd", 16'(sram_rd), 16'h0000);
        @(negedge clk);
        chk("led_map", 16'(led_map), 16'h000b);
    endtask

    task automatic t_sel;
        logic [6:0] sel;
        logic [8:0] exp;
        act({OP_MAP_ADDR, 7'h07}, 7'h07);
        for (int s = 0; s < 12; s++)
        begin
            sel = (s == 11) ? 7'h7f : 7'(s);
            exp = (s >= 1 && s <= 9) ? 9'(1 << (s - 1)) : 9'h000;
            issue({OP_MAP_SEL, sel});
            chk("led_map", 16'(led_map), 16'(exp));
            chk("fader_en", 16'(fader_en), 16'h0000);
        end
    endtask

    task automatic t_duty;
        issue({OP_MAP_SEL, 7'h03});
        higher_map = 9'h004;
        host_duty_we = 9'h1ff;
        duty_push = 1'b1;
        #1;
        chk("led_own", 16'(led_own), 16'h0000);
        chk("duty_eng_we", 16'(duty_eng_we), 16'h0000);
        @(negedge clk);
        higher_map = 9'h000;
        #1;
        chk("led_own", 16'(led_own), 16'h0004);
        chk("host_we_eff", 16'(duty_host_we_eff), 16'h01fb);
        chk("duty_eng_we", 16'(duty_eng_we), 16'h0004);
        @(negedge clk);
        duty_push = 1'b0;
        #1;
        chk("duty_eng_we", 16'(duty_eng_we), 16'h0000);
        @(negedge clk);
        issue({OP_MAP_SEL, 7'h00});
        chk("host_we_eff", 16'(duty_host_we_eff), 16'h01ff);
        host_duty_we = 9'h000;
    endtask

    task automatic t_events;
        issue(INSTR_ALERT);
        chk("alert_pulse", 16'(alert_pulse), 16'h0001);
        @(negedge clk);
        chk("alert_pulse", 16'(alert_pulse), 16'h0000);
        issue(INSTR_SYNC_FLUSH);
        chk("flush_pulse", 16'(sync_flush_pulse), 16'h0001);
        for (int c = 0; c < 4; c++)
        begin
            issue({PFX_SKIP, 2'(c), 5'(3 + 7 * c), 2'(c), 2'(3 - c)});
            chk("skip_pulse", 16'(skip_pulse), 16'h0001);
            chk("skip_cond", 16'(skip_cond), 16'(c));
            chk("skip_count", 16'(skip_count), 16'(3 + 7 * c));
            chk("skip_var1", 16'(skip_var1), 16'(c));
            chk("skip_var2", 16'(skip_var2), 16'(3 - c));
        end
    endtask

    task automatic t_branch;
        int c;
        prog_base = 8'h20;
        cur_pc = 8'h05;
        issue({PFX_BRANCH, 6'h01, 7'h0a});
        chk("pc_load", 16'(pc_load), 16'h0001);
        chk("pc_target", 16'(pc_target), 16'h002a);
        chk("instr_ready", 16'(instr_ready), 16'h0000);
        wait_ready(60000, c);
        chk("busy_len", 16'(c >= 15 * ENG_TICK_DIV &&
            c <= 16 * ENG_TICK_DIV + 4), 16'h0001);
        issue({PFX_BRANCH, 6'h01, 7'h0a});
        chk("pc_load", 16'(pc_load), 16'h0000);
        do_reset(2);
        var_data = 8'h02;
        instr = {PFX_BRANCH_VAR, 7'h03, 2'h2};
        instr_valid = 1'b1;
        #1;
        chk("var_sel", 16'(var_sel), 16'h0002);
        @(negedge clk);
        instr_valid = 1'b0;
        chk("pc_load", 16'(pc_load), 16'h0001);
        chk("pc_target", 16'(pc_target), 16'h0023);
        do_reset(2);
        issue({PFX_BRANCH, 6'h00, 7'h11});
        chk("pc_load", 16'(pc_load), 16'h0001);
        chk("pc_target", 16'(pc_target), 16'h0031);
        do_reset(2);
    endtask

    task automatic t_end_sync;
        for (int f = 0; f < 2; f++)
        begin
            issue({PFX_END, 1'(f), 1'(1 - f), END_LOW_ZERO});
            chk("end_pulse", 16'(end_pulse), 16'h0001);
            chk("end_alert", 16'(end_alert), 16'(f));
            chk("end_reset", 16'(end_reset), 16'(1 - f));
            do_reset(2);
        end
        issue(16'hfd3a);
        chk("sync_pulse", 16'(sync_pulse), 16'h0001);
        chk("sync_wait", 16'(sync_wait), 16'h000a);
        chk("sync_send", 16'(sync_send), 16'h0005);
        do_reset(2);
        issue(INSTR_RESTART);
        chk("instr_ready", 16'(instr_ready), 16'h0000);
        chk("pc_load", 16'(pc_load), 16'h0001);
        do_reset(2);
    endtask

    initial
    begin
        rst_n = 1'b0;
        instr_valid = 1'b0;
        instr = 16'h0000;
        cur_pc = 8'h00;
        prog_base = 8'h00;
        var_data = 8'h00;
        higher_map = 9'h000;
        host_duty_we = 9'h000;
        duty_push = 1'b0;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        chk("instr_ready", 16'(instr_ready), 16'h0001);
        chk("led_map", 16'(led_map), 16'h0000);
        t_table();
        t_jump();
        t_sel();
        t_duty();
        t_events();
        t_end_sync();
        t_branch();
        print_verdict();
    end
endmodule
